// *** rtl/asps_consts.svh ***
// Purpose: numeric constants of the analog set-point scaler
// Assumes: levels in 0.1 % steps, frequencies in 0.01 Hz steps
// Notes: included by the package and by every design file
`ifndef ASPS_CONSTS_SVH
`define ASPS_CONSTS_SVH

// data widths
`define ASPS_LVL_W 12
`define ASPS_FRQ_W 16
`define ASPS_ADC_W 12

// filter setting range and reset value
`define ASPS_FILT_RST 4'h1
`define ASPS_FILT_MAX 4'h8
// shift at setting 0; tick 1.25 ms * 2^2 gives about 5 ms
`define ASPS_FILT_SHIFT_BASE 4'h2

// frequency limits and resets (0.01 Hz)
`define ASPS_FRQ_MAX 16'h9c40
`define ASPS_GAIN_F_RST 16'h1388
`define ASPS_BIAS_F_RST 16'h0000

// level limits and resets (0.1 %)
`define ASPS_LVL_MAX 12'hbb8
`define ASPS_A_BIAS_L_RST 12'h000
`define ASPS_B_BIAS_L_RST 12'h0c8
`define ASPS_GAIN_L_RST 12'h3e8

// full-scale factors: adc code * factor >> 12 gives 0.1 %
`define ASPS_SCALE_FULL 12'h3e8
`define ASPS_SCALE_HALF 12'h7d0

// range selector codes for the first channel
`define ASPS_RANGE_10V_LO 4'h0
`define ASPS_RANGE_10V_HI 4'ha

// second channel input selector codes
`define ASPS_B_SEL_MA 2'h0
`define ASPS_B_SEL_5V 2'h1

// write protect codes
`define ASPS_WP_STOPPED 2'h0
`define ASPS_WP_ANY 2'h2

// filter tick period and clock period
`define ASPS_TICK_NS 1250000
`define ASPS_CLK_NS 50
`define ASPS_TICK_CYC (`ASPS_TICK_NS / `ASPS_CLK_NS)

`endif

// *** rtl/asps_pkg.sv ***
// Purpose: types of the analog set-point scaler
// Assumes: constants come from asps_consts.svh
// Notes: state of each rtl module is one packed struct, plus filt_stb_q in asps_top
`include "asps_consts.svh"

package asps_pkg;

   // parameter selector for the write port
   typedef enum logic [3:0] {
      SEL_FILTER,
      SEL_A_GAIN_F,
      SEL_B_GAIN_F,
      SEL_DISP,
      SEL_A_BIAS_F,
      SEL_A_BIAS_L,
      SEL_A_GAIN_L,
      SEL_B_BIAS_F,
      SEL_B_BIAS_L,
      SEL_B_GAIN_L
   } asps_param_sel_type;

   // bias and gain points of one channel
   typedef struct packed {
      logic [`ASPS_LVL_W-1:0] bias_l;
      logic [`ASPS_LVL_W-1:0] gain_l;
      logic [`ASPS_FRQ_W-1:0] bias_f;
      logic [`ASPS_FRQ_W-1:0] gain_f;
   } asps_chan_cfg_type;

   typedef struct packed {
      logic [2*`ASPS_LVL_W-1:0] y;
   } asps_filt_state_type;

   typedef struct packed {
      logic [`ASPS_FRQ_W-1:0] freq;
      logic valid;
   } asps_scale_state_type;

   typedef struct packed {
      logic [3:0] filt_set;
      logic disp_unit;
      asps_chan_cfg_type cfg_a;
      asps_chan_cfg_type cfg_b;
      logic en_meta;
      logic en_sync;
      logic [23:0] tick_cnt;
      logic ack;
      logic err;
      logic [`ASPS_FRQ_W-1:0] freq;
      logic cmd_valid;
      logic src_b;
      logic [`ASPS_LVL_W-1:0] disp_val;
   } asps_top_state_type;

endpackage : asps_pkg

// *** rtl/asps_lag_filter.sv ***
// Purpose: first-order lag on one level stream
// Assumes: tick_i is a one-cycle enable at the filter rate
// Notes: y += (x - y) / 2^shift, 12 fraction bits kept
`timescale 1ns/1ps
`default_nettype none
`include "asps_consts.svh"

module asps_lag_filter (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic [3:0] shift_i,
   input wire logic [`ASPS_LVL_W-1:0] x_i,
   output logic [`ASPS_LVL_W-1:0] y_o
);

   asps_pkg::asps_filt_state_type s_q, s_d;
   logic signed [2*`ASPS_LVL_W:0] diff;
   logic signed [2*`ASPS_LVL_W:0] step;

   // step toward the input, scaled by the time constant
   always_comb begin
      s_d = s_q;
      diff = $signed({1'b0, x_i, {`ASPS_LVL_W{1'b0}}}) - $signed({1'b0, s_q.y});
      step = diff >>> shift_i;
      if (tick_i) begin
         s_d.y = s_q.y + step[2*`ASPS_LVL_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign y_o = s_q.y[2*`ASPS_LVL_W-1:`ASPS_LVL_W];

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   chk_filter_rise: assert property (
      tick_i && (x_i > y_o) |=> s_q.y >= $past(s_q.y))
      else $error("filter moved away from a higher input");

   chk_filter_hold: assert property (
      !tick_i |=> $stable(s_q.y))
      else $error("filter changed without a tick");

endmodule : asps_lag_filter
`default_nettype wire

// *** rtl/asps_lin_scale.sv ***
// Purpose: bias/gain mapping of one filtered level to a frequency
// Assumes: cfg_i is stable around stb_i
// Notes: result registered one cycle after stb_i, rounded to nearest
`timescale 1ns/1ps
`default_nettype none
`include "asps_consts.svh"

module asps_lin_scale (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic stb_i,
   input wire logic [`ASPS_LVL_W-1:0] lvl_i,
   input wire asps_pkg::asps_chan_cfg_type cfg_i,
   output logic [`ASPS_FRQ_W-1:0] freq_o,
   output logic valid_o
);

   asps_pkg::asps_scale_state_type s_q, s_d;
   logic [`ASPS_LVL_W-1:0] dl;
   logic [`ASPS_LVL_W-1:0] span;
   logic signed [`ASPS_FRQ_W:0] df;
   logic signed [`ASPS_LVL_W+`ASPS_FRQ_W+1:0] prod;
   logic [`ASPS_LVL_W+`ASPS_FRQ_W:0] mag;
   logic [`ASPS_LVL_W+`ASPS_FRQ_W:0] q;

   // clamp below bias and above gain, interpolate between
   always_comb begin
      s_d = s_q;
      s_d.valid = stb_i;
      dl = lvl_i - cfg_i.bias_l;
      span = cfg_i.gain_l - cfg_i.bias_l;
      df = $signed({1'b0, cfg_i.gain_f}) - $signed({1'b0, cfg_i.bias_f});
      prod = $signed({1'b0, dl}) * df;
      mag = prod[`ASPS_LVL_W+`ASPS_FRQ_W+1] ? (`ASPS_LVL_W+`ASPS_FRQ_W+1)'(-prod)
                                            : prod[`ASPS_LVL_W+`ASPS_FRQ_W:0];
      q = '0;
      if (stb_i) begin
         if (lvl_i <= cfg_i.bias_l) begin
            s_d.freq = cfg_i.bias_f;
         end else if (lvl_i >= cfg_i.gain_l) begin
            s_d.freq = cfg_i.gain_f;
         end else begin
            q = (mag + (`ASPS_LVL_W+`ASPS_FRQ_W+1)'(span >> 1)) / span;
            if (df < 0) begin
               s_d.freq = cfg_i.bias_f - q[`ASPS_FRQ_W-1:0];
            end else begin
               s_d.freq = cfg_i.bias_f + q[`ASPS_FRQ_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign freq_o = s_q.freq;
   assign valid_o = s_q.valid;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   chk_clamp_low: assert property (
      stb_i && lvl_i <= cfg_i.bias_l |=> valid_o && freq_o == $past(cfg_i.bias_f))
      else $error("level below bias not clamped to bias frequency");

   chk_clamp_high: assert property (
      stb_i && lvl_i >= cfg_i.gain_l && lvl_i > cfg_i.bias_l
      |=> valid_o && freq_o == $past(cfg_i.gain_f))
      else $error("level above gain not clamped to gain frequency");

   chk_interp_span: assert property (
      stb_i && lvl_i > cfg_i.bias_l && lvl_i < cfg_i.gain_l
      |=> (freq_o >= $past(cfg_i.bias_f) && freq_o <= $past(cfg_i.gain_f))
       || (freq_o <= $past(cfg_i.bias_f) && freq_o >= $past(cfg_i.gain_f)))
      else $error("interpolated frequency outside bias and gain points");

endmodule : asps_lin_scale
`default_nettype wire

// *** rtl/asps_top.sv ***
// Purpose: filters and scales two analog set-points to a frequency command
// Assumes: adc samples are on clock_i, full code is 10 V or 20 mA
// Notes: levels in 0.1 % units, frequencies in 0.01 Hz units
//
// Notes on behaviour
// - lag filter per sample, setting 0-8, reset 1
// - time constant about 5 ms to 1.28 s
// - channel A gain frequency 0-400 Hz, 50 Hz
// - channel B gain frequency 0-400 Hz, 50 Hz
// - channel A bias frequency, default 0 Hz
// - channel A bias level 0-300 %, default 0
// - channel A gain level, default 100 %
// - channel B bias level, default 20 %
// - channel B gain level, default 100 %
// - channel B bias frequency, default 0 Hz
// - channel A below bias gives bias frequency
// - channel A above gain gives gain frequency
// - channel B below bias gives bias frequency
// - channel B above gain gives gain frequency
// - linear slope set by bias and gain points
// - bias above gain frequency gives falling slope
// - gain frequency alone rescales maximum command
// - display unit: 0 percent, 1 volts/milliamps
// - display unit writable while running, any protection
// - settings writable only when group select zero
// - channel B used only while enable asserted
// - channel A 10 V when select 0/10
`timescale 1ns/1ps
`default_nettype none
`include "asps_consts.svh"

module asps_top #(
   parameter int TICK_CYCLES = `ASPS_TICK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [`ASPS_ADC_W-1:0] sample_a_i,
   input wire logic [`ASPS_ADC_W-1:0] sample_b_i,
   input wire logic ch_b_enable_i,
   input wire logic [3:0] ch_a_range_select_i,
   input wire logic [1:0] ch_b_input_select_i,
   input wire logic [13:0] user_group_read_select_i,
   input wire logic [1:0] write_protect_select_i,
   input wire logic drive_running_i,
   input wire logic param_wr_i,
   input wire asps_pkg::asps_param_sel_type param_sel_i,
   input wire logic [`ASPS_FRQ_W-1:0] param_data_i,
   output logic param_ack_o,
   output logic param_err_o,
   output logic [`ASPS_FRQ_W-1:0] freq_cmd_o,
   output logic cmd_valid_o,
   output logic cmd_src_b_o,
   output logic [`ASPS_LVL_W-1:0] level_display_o,
   output logic level_display_unit_select_o,
   output logic [3:0] filter_time_setting_o
);

   asps_pkg::asps_top_state_type s_q, s_d;
   logic tick;
   logic ten_v_a;
   logic wr_ok;
   logic rng_ok;
   logic [`ASPS_LVL_W-1:0] factor [2];
   logic [`ASPS_ADC_W-1:0] sample [2];
   logic [`ASPS_LVL_W-1:0] lvl_raw [2];
   logic [`ASPS_LVL_W-1:0] lvl_filt [2];
   asps_pkg::asps_chan_cfg_type cfg [2];
   logic [`ASPS_FRQ_W-1:0] freq_ch [2];
   logic valid_ch [2];
   logic filt_stb_q;
   logic [3:0] shift;
   logic [`ASPS_LVL_W-1:0] lvl_sel;

   // filter rate enable from the free-running divider
   assign tick = (s_q.tick_cnt == 24'h000000);

   // full-scale factor per channel
   assign ten_v_a = (ch_a_range_select_i == `ASPS_RANGE_10V_LO)
                 || (ch_a_range_select_i == `ASPS_RANGE_10V_HI);
   assign factor[0] = ten_v_a ? `ASPS_SCALE_FULL : `ASPS_SCALE_HALF;
   assign factor[1] = (ch_b_input_select_i == `ASPS_B_SEL_5V)
                    ? `ASPS_SCALE_HALF : `ASPS_SCALE_FULL;
   assign sample[0] = sample_a_i;
   assign sample[1] = sample_b_i;
   assign cfg[0] = s_q.cfg_a;
   assign cfg[1] = s_q.cfg_b;
   assign shift = s_q.filt_set + `ASPS_FILT_SHIFT_BASE;

   // per channel: level conversion, lag filter, then scaling
   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic [2*`ASPS_LVL_W-1:0] prod;
      assign prod = sample[c] * factor[c];
      assign lvl_raw[c] = prod[2*`ASPS_LVL_W-1:`ASPS_LVL_W];

      asps_lag_filter u_filt (
         .clock_i(clock_i),
         .rst_b_i(rst_b_i),
         .tick_i(tick),
         .shift_i(shift),
         .x_i(lvl_raw[c]),
         .y_o(lvl_filt[c])
      );

      asps_lin_scale u_scale (
         .clock_i(clock_i),
         .rst_b_i(rst_b_i),
         .stb_i(filt_stb_q),
         .lvl_i(lvl_filt[c]),
         .cfg_i(cfg[c]),
         .freq_o(freq_ch[c]),
         .valid_o(valid_ch[c])
      );
   end

   // scaling runs the cycle after the filter has stepped
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         filt_stb_q <= 1'b0;
      end else begin
         filt_stb_q <= tick;
      end
   end

   // write permission: group select, then protection or display exemption
   always_comb begin
      wr_ok = 1'b0;
      if (user_group_read_select_i == 14'h0000) begin
         if (param_sel_i == asps_pkg::SEL_DISP) begin
            wr_ok = 1'b1;
         end else if (write_protect_select_i == `ASPS_WP_ANY) begin
            wr_ok = 1'b1;
         end else if (write_protect_select_i == `ASPS_WP_STOPPED) begin
            wr_ok = !drive_running_i;
         end
      end
   end

   // value range per parameter
   always_comb begin
      rng_ok = 1'b0;
      unique case (param_sel_i)
         asps_pkg::SEL_FILTER: begin
            rng_ok = param_data_i <= 16'(`ASPS_FILT_MAX);
         end
         asps_pkg::SEL_DISP: begin
            rng_ok = param_data_i <= 16'h0001;
         end
         asps_pkg::SEL_A_GAIN_F, asps_pkg::SEL_B_GAIN_F,
         asps_pkg::SEL_A_BIAS_F, asps_pkg::SEL_B_BIAS_F: begin
            rng_ok = param_data_i <= `ASPS_FRQ_MAX;
         end
         asps_pkg::SEL_A_BIAS_L, asps_pkg::SEL_A_GAIN_L,
         asps_pkg::SEL_B_BIAS_L, asps_pkg::SEL_B_GAIN_L: begin
            rng_ok = param_data_i <= 16'(`ASPS_LVL_MAX);
         end
         default: begin
            rng_ok = 1'b0;
         end
      endcase
   end

   // selected channel's filtered level for the display
   assign lvl_sel = s_q.en_sync ? lvl_filt[1] : lvl_filt[0];

   // next state
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.err = 1'b0;
      s_d.cmd_valid = 1'b0;
      // two-flop synchroniser of the enable pin
      s_d.en_meta = ch_b_enable_i;
      s_d.en_sync = s_q.en_meta;
      // divider for the filter tick
      if (s_q.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
         s_d.tick_cnt = 24'h000000;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 24'h000001;
      end
      // parameter writes, refused writes leave the store alone
      if (param_wr_i) begin
         if (wr_ok && rng_ok) begin
            s_d.ack = 1'b1;
            unique case (param_sel_i)
               asps_pkg::SEL_FILTER: begin
                  s_d.filt_set = param_data_i[3:0];
               end
               asps_pkg::SEL_DISP: begin
                  s_d.disp_unit = param_data_i[0];
               end
               asps_pkg::SEL_A_GAIN_F: begin
                  s_d.cfg_a.gain_f = param_data_i;
               end
               asps_pkg::SEL_B_GAIN_F: begin
                  s_d.cfg_b.gain_f = param_data_i;
               end
               asps_pkg::SEL_A_BIAS_F: begin
                  s_d.cfg_a.bias_f = param_data_i;
               end
               asps_pkg::SEL_A_BIAS_L: begin
                  s_d.cfg_a.bias_l = param_data_i[`ASPS_LVL_W-1:0];
               end
               asps_pkg::SEL_A_GAIN_L: begin
                  s_d.cfg_a.gain_l = param_data_i[`ASPS_LVL_W-1:0];
               end
               asps_pkg::SEL_B_BIAS_F: begin
                  s_d.cfg_b.bias_f = param_data_i;
               end
               asps_pkg::SEL_B_BIAS_L: begin
                  s_d.cfg_b.bias_l = param_data_i[`ASPS_LVL_W-1:0];
               end
               asps_pkg::SEL_B_GAIN_L: begin
                  s_d.cfg_b.gain_l = param_data_i[`ASPS_LVL_W-1:0];
               end
               default: begin
                  s_d.err = 1'b1;
               end
            endcase
         end else begin
            s_d.err = 1'b1;
         end
      end
      // command from channel B only while its enable is high
      if (valid_ch[0]) begin
         s_d.cmd_valid = 1'b1;
         s_d.src_b = s_q.en_sync;
         s_d.freq = s_q.en_sync ? freq_ch[1] : freq_ch[0];
      end
      // display value in 0.1 % or in 0.01 V / 0.01 mA
      if (valid_ch[0]) begin
         if (!s_q.disp_unit) begin
            s_d.disp_val = lvl_sel;
         end else if (!s_q.en_sync) begin
            s_d.disp_val = ten_v_a ? lvl_sel : (lvl_sel >> 1);
         end else if (ch_b_input_select_i == `ASPS_B_SEL_MA) begin
            s_d.disp_val = {lvl_sel[`ASPS_LVL_W-2:0], 1'b0};
         end else begin
            s_d.disp_val = (factor[1] == `ASPS_SCALE_HALF) ? (lvl_sel >> 1) : lvl_sel;
         end
      end
   end

   // state register with documented defaults
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
         s_q.filt_set <= `ASPS_FILT_RST;
         s_q.cfg_a.bias_l <= `ASPS_A_BIAS_L_RST;
         s_q.cfg_a.gain_l <= `ASPS_GAIN_L_RST;
         s_q.cfg_a.bias_f <= `ASPS_BIAS_F_RST;
         s_q.cfg_a.gain_f <= `ASPS_GAIN_F_RST;
         s_q.cfg_b.bias_l <= `ASPS_B_BIAS_L_RST;
         s_q.cfg_b.gain_l <= `ASPS_GAIN_L_RST;
         s_q.cfg_b.bias_f <= `ASPS_BIAS_F_RST;
         s_q.cfg_b.gain_f <= `ASPS_GAIN_F_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign param_ack_o = s_q.ack;
   assign param_err_o = s_q.err;
   assign freq_cmd_o = s_q.freq;
   assign cmd_valid_o = s_q.cmd_valid;
   assign cmd_src_b_o = s_q.src_b;
   assign level_display_o = s_q.disp_val;
   assign level_display_unit_select_o = s_q.disp_unit;
   assign filter_time_setting_o = s_q.filt_set;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   chk_group_gate: assert property (
      param_wr_i && user_group_read_select_i != 14'h0000
      |=> param_err_o && !param_ack_o)
      else $error("write accepted with nonzero group select");

   chk_disp_any_mode: assert property (
      param_wr_i && user_group_read_select_i == 14'h0000
      && param_sel_i == asps_pkg::SEL_DISP && param_data_i <= 16'h0001
      |=> param_ack_o && s_q.disp_unit == $past(param_data_i[0]))
      else $error("display unit write refused");

   chk_freq_limit: assert property (
      param_wr_i && param_sel_i == asps_pkg::SEL_A_GAIN_F
      && param_data_i > `ASPS_FRQ_MAX
      |=> param_err_o && $stable(s_q.cfg_a.gain_f))
      else $error("out-of-range gain frequency stored");

   chk_filter_limit: assert property (
      s_q.filt_set <= `ASPS_FILT_MAX)
      else $error("filter setting above its maximum");

   chk_source_select: assert property (
      valid_ch[0] |=> cmd_valid_o && cmd_src_b_o == $past(s_q.en_sync)
      && freq_cmd_o == ($past(s_q.en_sync) ? $past(freq_ch[1]) : $past(freq_ch[0])))
      else $error("command taken from wrong channel");

   chk_cmd_latency: assert property (
      tick |-> ##3 cmd_valid_o)
      else $error("command not issued three cycles after tick");

   // every write gets exactly one answer, and no answer comes unasked
   chk_answer_once: assert property (
      param_wr_i |=> param_ack_o != param_err_o)
      else $error("write answered by neither or both of ack and err");

   chk_answer_none: assert property (
      !param_wr_i |=> !param_ack_o && !param_err_o)
      else $error("answer pulse without a write");

   // protection code 1 locks all but the display unit
   chk_protect_lock: assert property (
      param_wr_i && user_group_read_select_i == 14'h0000
      && param_sel_i != asps_pkg::SEL_DISP && write_protect_select_i == 2'h1
      |=> param_err_o)
      else $error("write accepted while protection locks it");

   // protection code 0 refuses all but display unit writes while the drive runs
   chk_running_lock: assert property (
      param_wr_i && user_group_read_select_i == 14'h0000
      && param_sel_i != asps_pkg::SEL_DISP && write_protect_select_i == `ASPS_WP_STOPPED
      && drive_running_i |=> param_err_o)
      else $error("write accepted while running and protected");

   // an accepted filter write shows up on the setting output
   chk_filter_store: assert property (
      param_wr_i && wr_ok && param_sel_i == asps_pkg::SEL_FILTER
      && param_data_i <= 16'(`ASPS_FILT_MAX)
      |=> filter_time_setting_o == $past(param_data_i[3:0]))
      else $error("accepted filter setting not stored");

   // only codes 0 and 10 give channel a its 10 V span
   chk_range_code: assert property (
      ten_v_a == (factor[0] == `ASPS_SCALE_FULL))
      else $error("channel a full-scale factor disagrees with range");

   // main scenarios worth seeing once
   cov_src_b: cover property (cmd_valid_o && cmd_src_b_o);
   cov_disp_running: cover property (param_wr_i && drive_running_i
      && param_sel_i == asps_pkg::SEL_DISP ##1 param_ack_o);
   cov_inverse: cover property (cmd_valid_o && s_q.cfg_a.bias_f > s_q.cfg_a.gain_f);
   cov_unit_volts: cover property (cmd_valid_o && level_display_unit_select_o);
   cov_refused: cover property (param_err_o);

endmodule : asps_top
`default_nettype wire

// *** bench/asps_far_side.sv ***
// Purpose: far-side model, adc channels and frequency command consumer
// Assumes: codes and enable change only at the falling edge
// Notes: a command is taken only in the cycle its valid pulse stands
`timescale 1ns/1ps
`default_nettype none
`include "asps_consts.svh"

module asps_far_side (
   input wire logic clock_i,
   input wire logic [`ASPS_ADC_W-1:0] code_a_i,
   input wire logic [`ASPS_ADC_W-1:0] code_b_i,
   input wire logic enable_i,
   input wire logic cmd_valid_i,
   input wire logic [`ASPS_FRQ_W-1:0] freq_cmd_i,
   input wire logic src_b_i,
   output logic [`ASPS_ADC_W-1:0] sample_a_o,
   output logic [`ASPS_ADC_W-1:0] sample_b_o,
   output logic ch_b_enable_o,
   output logic [`ASPS_FRQ_W-1:0] last_freq_o,
   output logic last_src_b_o
);
   // adc channels present steady level codes
   assign sample_a_o = code_a_i;
   assign sample_b_o = code_b_i;
   assign ch_b_enable_o = enable_i;

   // consumer latches the command in its valid cycle only
   always_ff @(posedge clock_i) begin
      if (cmd_valid_i) begin
         last_freq_o <= freq_cmd_i;
         last_src_b_o <= src_b_i;
      end
   end
endmodule : asps_far_side
`default_nettype wire

// *** bench/analog_setpoint_scaler_bench.sv ***
// Purpose: self-checking bench of the set-point scaler
// Assumes: tick shortened to 8 cycles, inputs driven at falling edge
// Notes: levels approached from above so filtered values are exact
`timescale 1ns/1ps
`default_nettype none
`include "asps_consts.svh"
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module analog_setpoint_scaler_bench;
   localparam int TK = 8;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [11:0] code_a = 12'h000, code_b = 12'h000, sa, sb;
   logic en = 1'b0, en_s, wr = 1'b0, run = 1'b0, ack, err, cv, src, unit, lsrc;
   logic [3:0] range = 4'h0, fset;
   logic [1:0] bsel = 2'h2, wp = 2'h2;
   logic [13:0] group = 14'h0000;
   logic [15:0] data = 16'h0000, freq, lfreq;
   logic [11:0] disp;
   asps_pkg::asps_param_sel_type sel = asps_pkg::SEL_FILTER;
   int n_errors = 0, n_tests = 0, cycles = 0;

   asps_top #(.TICK_CYCLES(TK)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .sample_a_i(sa), .sample_b_i(sb), .ch_b_enable_i(en_s),
      .ch_a_range_select_i(range), .ch_b_input_select_i(bsel),
      .user_group_read_select_i(group), .write_protect_select_i(wp),
      .drive_running_i(run), .param_wr_i(wr), .param_sel_i(sel), .param_data_i(data),
      .param_ack_o(ack), .param_err_o(err), .freq_cmd_o(freq), .cmd_valid_o(cv),
      .cmd_src_b_o(src), .level_display_o(disp), .level_display_unit_select_o(unit),
      .filter_time_setting_o(fset));

   asps_far_side far (.clock_i(clock_i), .code_a_i(code_a), .code_b_i(code_b),
      .enable_i(en), .cmd_valid_i(cv), .freq_cmd_i(freq), .src_b_i(src),
      .sample_a_o(sa), .sample_b_o(sb), .ch_b_enable_o(en_s),
      .last_freq_o(lfreq), .last_src_b_o(lsrc));

   // clock and cycle ceiling
   initial forever #25 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         final_report();
      end
   end

   // verdict and end of run
   task automatic final_report();
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   // one write, answer looked at in the cycle it stands
   task automatic wr_chk(input asps_pkg::asps_param_sel_type s, input logic [15:0] d,
                         input logic ok);
      @(negedge clock_i);
      wr = 1'b1;
      sel = s;
      data = d;
      @(negedge clock_i);
      wr = 1'b0;
      `CHECK("param_ack", ok, ack)
      `CHECK("param_err", !ok, err)
   endtask : wr_chk

   // let a number of filter ticks pass
   task automatic settle(input int n);
      repeat (n * TK) @(negedge clock_i);
   endtask : settle

   task automatic t_reset();
      `CHECK("filter_set", 4'h1, fset)
      `CHECK("disp_unit", 1'b0, unit)
      `CHECK("freq", 16'h0000, freq)
   endtask : t_reset

   // default points of channel a, level 50 % gives 25 Hz
   task automatic t_defaults();
      code_a = 12'hfff;
      settle(100);
      code_a = 12'h800;
      settle(160);
      `CHECK("disp_level", 12'h1f4, disp)
      `CHECK("freq_dflt", 16'h09c4, lfreq)
   endtask : t_defaults

   task automatic t_perm();
      group = 14'h0001;
      wr_chk(asps_pkg::SEL_FILTER, 16'h0000, 1'b0);
      group = 14'h0000;
      wp = 2'h1;
      wr_chk(asps_pkg::SEL_FILTER, 16'h0000, 1'b0);
      wr_chk(asps_pkg::SEL_DISP, 16'h0001, 1'b1);
      `CHECK("disp_unit", 1'b1, unit)
      wp = 2'h0;
      run = 1'b1;
      wr_chk(asps_pkg::SEL_FILTER, 16'h0000, 1'b0);
      wr_chk(asps_pkg::SEL_DISP, 16'h0000, 1'b1);
      run = 1'b0;
      wp = 2'h2;
      wr_chk(asps_pkg::SEL_FILTER, 16'h0009, 1'b0);
      wr_chk(asps_pkg::SEL_A_GAIN_F, 16'h9c41, 1'b0);
      wr_chk(asps_pkg::SEL_A_BIAS_L, 16'h0bb9, 1'b0);
      wr_chk(asps_pkg::SEL_FILTER, 16'h0000, 1'b1);
      `CHECK("filter_set", 4'h0, fset)
   endtask : t_perm

   // channel a: clamps, rising and falling slope, gain-only rescale
   task automatic t_map_a();
      wr_chk(asps_pkg::SEL_A_BIAS_L, 16'h00c8, 1'b1);
      wr_chk(asps_pkg::SEL_A_GAIN_L, 16'h0320, 1'b1);
      wr_chk(asps_pkg::SEL_A_BIAS_F, 16'h03e8, 1'b1);
      wr_chk(asps_pkg::SEL_A_GAIN_F, 16'h0fa0, 1'b1);
      code_a = 12'hfff;
      settle(80);
      `CHECK("freq_hi", 16'h0fa0, lfreq)
      code_a = 12'h400;
      settle(80);
      `CHECK("freq_mid", 16'h04e2, lfreq)
      wr_chk(asps_pkg::SEL_A_BIAS_F, 16'h0fa0, 1'b1);
      wr_chk(asps_pkg::SEL_A_GAIN_F, 16'h03e8, 1'b1);
      settle(4);
      `CHECK("freq_fall", 16'h0ea6, lfreq)
      code_a = 12'h000;
      settle(40);
      `CHECK("freq_lo", 16'h0fa0, lfreq)
      code_a = 12'hfff;
      settle(80);
      wr_chk(asps_pkg::SEL_A_GAIN_F, 16'h07d0, 1'b1);
      settle(4);
      `CHECK("freq_resc", 16'h07d0, lfreq)
   endtask : t_map_a

   // channel b replaces a only while enabled
   task automatic t_chan_b();
      en = 1'b1;
      code_b = 12'h000;
      settle(40);
      `CHECK("src_b", 1'b1, lsrc)
      `CHECK("freq_b_lo", 16'h0000, lfreq)
      wr_chk(asps_pkg::SEL_B_GAIN_L, 16'h0258, 1'b1);
      code_b = 12'hfff;
      settle(80);
      `CHECK("freq_b_hi", 16'h1388, lfreq)
      en = 1'b0;
      settle(4);
      `CHECK("src_a", 1'b0, lsrc)
      `CHECK("freq_a", 16'h07d0, lfreq)
   endtask : t_chan_b

   // channel a full scale follows the range selector
   task automatic t_range();
      range = 4'h1;
      code_a = 12'hfff;
      settle(80);
      code_a = 12'h400;
      settle(80);
      `CHECK("disp_5v", 12'h1f4, disp)
      wr_chk(asps_pkg::SEL_DISP, 16'h0001, 1'b1);
      settle(2);
      `CHECK("disp_volts", 12'h0fa, disp)
      wr_chk(asps_pkg::SEL_DISP, 16'h0000, 1'b1);
      range = 4'ha;
      code_a = 12'hfff;
      settle(80);
      code_a = 12'h400;
      settle(80);
      `CHECK("disp_10v", 12'h0fa, disp)
   endtask : t_range

   // main sequence
   initial begin
      repeat (6) @(negedge clock_i);
      rst_b_i = 1'b1;
      @(negedge clock_i);
      t_reset();
      t_defaults();
      t_perm();
      t_map_a();
      t_chan_b();
      t_range();
      final_report();
   end
endmodule : analog_setpoint_scaler_bench
`default_nettype wire
